// File: design/ssps_pkg.sv
/*
  ssps_pkg: shared constants and types of the status summary and port select block.
  assumes: a single 40 MHz core clock; axi4-lite register access.
*/
`default_nettype none

package ssps_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_HZ       = 40_000_000;  // core clock rate
  localparam int unsigned IDLE_MIN     = 5;           // idle time before a port change, minutes
  localparam longint unsigned IDLE_CYC = longint'(IDLE_MIN) * 60 * CLK_HZ;  // idle time in cycles

  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] OFS_STB  = 8'h00;  // status byte, read only
  localparam logic [7:0] OFS_SRE  = 8'h04;  // service request enable
  localparam logic [7:0] OFS_ESR  = 8'h08;  // event status, read only, sticky
  localparam logic [7:0] OFS_ESE  = 8'h0C;  // event status enable
  localparam logic [7:0] OFS_ESRC = 8'h10;  // event status clear, write only
  localparam logic [7:0] OFS_PORT = 8'h14;  // active port state, read only
  localparam logic [7:0] OFS_IST  = 8'h18;  // interrupt status, read only, sticky
  localparam logic [7:0] OFS_IEN  = 8'h1C;  // interrupt enable
  localparam logic [7:0] OFS_ICLR = 8'h20;  // interrupt clear, write only

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int unsigned STB_MAV = 4;  // message available bit
  localparam int unsigned STB_ESB = 5;  // event summary bit
  localparam int unsigned STB_MSS = 6;  // master summary bit
  localparam int unsigned IRQ_W   = 3;  // interrupt sources
  localparam int unsigned IRQ_SEL = 0;  // port selected
  localparam int unsigned IRQ_TRM = 1;  // command terminated
  localparam int unsigned IRQ_MSS = 2;  // service requested
  localparam logic [7:0] SRE_RST  = 8'h00;
  localparam logic [7:0] ESE_RST  = 8'h00;
  localparam logic [2:0] IEN_RST  = 3'h0;
  localparam logic [1:0] RESP_OK  = 2'h0;  // axi okay
  localparam logic [1:0] RESP_ERR = 2'h2;  // axi slverr

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    SSPS_NONE   = 2'b00,  // no port chosen yet
    SSPS_SERIAL = 2'b01,  // serial port owns the link
    SSPS_GPIB   = 2'b10   // ieee-488 port owns the link
  } ssps_port_t;

  // traffic seen on one port in one cycle
  typedef struct packed {
    logic       rx_valid;  // a byte arrived
    logic [7:0] rx_data;   // that byte
    logic       eoi;       // end marker with the byte (ieee-488 only)
  } ssps_rx_t;

endpackage

`default_nettype wire

// File: design/ssps_top.sv
/*
  ssps_top: picks the active remote port and builds the status byte.
  assumes: traffic strobes synchronous to core_clk; the response buffer
  reports its own fill state; axi4-lite master keeps the usual handshake.
*/
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module ssps_top #(
  parameter longint unsigned IDLE_CYCLES = ssps_pkg::IDLE_CYC  // idle time, shortenable
) (
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  // port traffic
  input  wire ssps_pkg::ssps_rx_t   serial_rx,
  input  wire ssps_pkg::ssps_rx_t   gpib_rx,
  // accepted traffic toward the command parser
  output var  ssps_pkg::ssps_rx_t   cmd_rx,
  output logic                      cmd_end,
  // device events and output buffer
  input  wire logic [7:0]           event_pulse,
  input  wire logic                 resp_pending,
  output logic [7:0]                status_byte,
  output logic                      srq_req,
  // axi4-lite slave
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // interrupt
  output logic                      irq
);

  // ****************************************
  // declarations
  // ****************************************
  localparam logic [7:0] NL_CHAR = 8'h0A;  // newline terminator
  localparam int unsigned IRQ_W_L = ssps_pkg::IRQ_W;  // interrupt sources, declared before first use

  ssps_pkg::ssps_port_t port_reg;    // active port
  logic [38:0]          idle_reg;    // idle cycle counter
  logic                 expired_reg; // idle time elapsed
  logic [7:0]           sre_reg;     // service request enable
  logic [7:0]           ese_reg;     // event status enable
  logic [7:0]           esr_reg;     // sticky event status
  logic [IRQ_W_L-1:0]   ist_reg;     // sticky interrupt status
  logic [IRQ_W_L-1:0]   ien_reg;     // interrupt enable
  logic                 mss_d_reg;   // previous summary, for edge

  logic                 ser_hit;     // serial traffic accepted
  logic                 gpib_hit;    // ieee-488 traffic accepted
  logic                 sel_evt;     // a new port was chosen
  logic                 term_evt;    // a command ended
  logic [7:0]           stb_live;    // status byte without summary
  logic                 mss_live;    // live summary
  logic [IRQ_W_L-1:0]   ev_vec;      // interrupt events

  // axi write side
  logic                 aw_have_reg; // address captured
  logic                 w_have_reg;  // data captured
  logic [7:0]           aw_addr_reg; // captured address
  logic [31:0]          w_data_reg;  // captured data
  logic [3:0]           w_strb_reg;  // captured strobes
  logic                 wr_fire;     // both parts present
  logic                 wr_ok;       // mapped write offset

  // ****************************************
  // port selection
  // ****************************************
  // accepted traffic: only the owner, or anyone when unowned or idle long enough
  always_comb begin
    ser_hit  = 1'b0;
    gpib_hit = 1'b0;
    if (port_reg == ssps_pkg::SSPS_NONE || expired_reg) begin
      // serial wins a same-cycle tie
      ser_hit  = serial_rx.rx_valid;
      gpib_hit = gpib_rx.rx_valid && !serial_rx.rx_valid;
    end else if (port_reg == ssps_pkg::SSPS_SERIAL) begin
      ser_hit  = serial_rx.rx_valid;
    end else begin
      gpib_hit = gpib_rx.rx_valid;
    end
  end

  assign sel_evt = (ser_hit && port_reg != ssps_pkg::SSPS_SERIAL) ||
                   (gpib_hit && port_reg != ssps_pkg::SSPS_GPIB);

  // owner register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_reg <= ssps_pkg::SSPS_NONE;
    end else if (ser_hit) begin
      port_reg <= ssps_pkg::SSPS_SERIAL;
    end else if (gpib_hit) begin
      port_reg <= ssps_pkg::SSPS_GPIB;
    end
  end

  // idle timer: restarts on owner traffic, saturates when elapsed
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_reg    <= 39'h0;
      expired_reg <= 1'b0;
    end else if (ser_hit || gpib_hit) begin
      idle_reg    <= 39'h0;
      expired_reg <= 1'b0;
    end else if (port_reg != ssps_pkg::SSPS_NONE && !expired_reg) begin
      if (idle_reg >= 39'(IDLE_CYCLES - 1)) begin
        expired_reg <= 1'b1;
      end else begin
        idle_reg <= idle_reg + 39'h1;
      end
    end
  end

  // ****************************************
  // command path
  // ****************************************
  // forward accepted bytes; eoi counts as a newline
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_rx  <= '0;
      cmd_end <= 1'b0;
    end else if (ser_hit) begin
      cmd_rx  <= serial_rx;
      cmd_end <= (serial_rx.rx_data == NL_CHAR);
    end else if (gpib_hit) begin
      cmd_rx  <= gpib_rx;
      cmd_end <= (gpib_rx.rx_data == NL_CHAR) || gpib_rx.eoi;
    end else begin
      cmd_rx  <= '0;
      cmd_end <= 1'b0;
    end
  end

  assign term_evt = (ser_hit && serial_rx.rx_data == NL_CHAR) ||
                    (gpib_hit && (gpib_rx.rx_data == NL_CHAR || gpib_rx.eoi));

  // ****************************************
  // status byte
  // ****************************************
  always_comb begin
    stb_live = 8'h00;
    stb_live[ssps_pkg::STB_ESB] = |(esr_reg & ese_reg);
    stb_live[ssps_pkg::STB_MAV] = resp_pending;
  end

  // summary from live bits, never held
  assign mss_live = |(stb_live & sre_reg);

  // registered status byte and service request
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_byte <= 8'h00;
      srq_req     <= 1'b0;
      mss_d_reg   <= 1'b0;
    end else begin
      status_byte <= stb_live | (8'(mss_live) << ssps_pkg::STB_MSS);
      srq_req     <= mss_live;
      mss_d_reg   <= mss_live;
    end
  end

  // ****************************************
  // bus write handshake
  // ****************************************
  assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;

  // take address and data in either order
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h0;
      w_strb_reg  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_have_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_have_reg <= 1'b0;
      end
    end
  end

  // ready flops: one beat each until consumed
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !aw_have_reg && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready  <= !w_have_reg && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  assign wr_ok = aw_addr_reg == ssps_pkg::OFS_SRE  || aw_addr_reg == ssps_pkg::OFS_ESE ||
                 aw_addr_reg == ssps_pkg::OFS_ESRC || aw_addr_reg == ssps_pkg::OFS_IEN ||
                 aw_addr_reg == ssps_pkg::OFS_ICLR;

  // write response
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= ssps_pkg::RESP_OK;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? ssps_pkg::RESP_OK : ssps_pkg::RESP_ERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************
  // software registers
  // ****************************************
  // enable masks, low byte lane only
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sre_reg <= ssps_pkg::SRE_RST;
      ese_reg <= ssps_pkg::ESE_RST;
      ien_reg <= ssps_pkg::IEN_RST;
    end else if (wr_fire && w_strb_reg[0]) begin
      if (aw_addr_reg == ssps_pkg::OFS_SRE) begin
        sre_reg <= w_data_reg[7:0];
      end else if (aw_addr_reg == ssps_pkg::OFS_ESE) begin
        ese_reg <= w_data_reg[7:0];
      end else if (aw_addr_reg == ssps_pkg::OFS_IEN) begin
        ien_reg <= w_data_reg[IRQ_W_L-1:0];
      end
    end
  end

  assign ev_vec = {mss_live && !mss_d_reg, term_evt, sel_evt};

  // sticky bits; a set in the clear cycle wins, one generate per bit
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_esr
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          esr_reg[gi] <= 1'b0;
        end else if (event_pulse[gi]) begin
          esr_reg[gi] <= 1'b1;
        end else if (wr_fire && w_strb_reg[0] && aw_addr_reg == ssps_pkg::OFS_ESRC && w_data_reg[gi]) begin
          esr_reg[gi] <= 1'b0;
        end
      end
    end
    for (gi = 0; gi < IRQ_W_L; gi++) begin : g_ist
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          ist_reg[gi] <= 1'b0;
        end else if (ev_vec[gi]) begin
          ist_reg[gi] <= 1'b1;
        end else if (wr_fire && w_strb_reg[0] && aw_addr_reg == ssps_pkg::OFS_ICLR && w_data_reg[gi]) begin
          ist_reg[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // interrupt line
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(ist_reg & ien_reg);
    end
  end

  // ****************************************
  // bus read
  // ****************************************
  // one read at a time; data one cycle after address
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= ssps_pkg::RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= ssps_pkg::RESP_OK;
      if (s_axi_araddr == ssps_pkg::OFS_STB) begin
        s_axi_rdata <= {24'h0, stb_live | (8'(mss_live) << ssps_pkg::STB_MSS)};
      end else if (s_axi_araddr == ssps_pkg::OFS_SRE) begin
        s_axi_rdata <= {24'h0, sre_reg};
      end else if (s_axi_araddr == ssps_pkg::OFS_ESR) begin
        s_axi_rdata <= {24'h0, esr_reg};
      end else if (s_axi_araddr == ssps_pkg::OFS_ESE) begin
        s_axi_rdata <= {24'h0, ese_reg};
      end else if (s_axi_araddr == ssps_pkg::OFS_PORT) begin
        s_axi_rdata <= {29'h0, expired_reg, port_reg};
      end else if (s_axi_araddr == ssps_pkg::OFS_IST) begin
        s_axi_rdata <= {29'h0, ist_reg};
      end else if (s_axi_araddr == ssps_pkg::OFS_IEN) begin
        s_axi_rdata <= {29'h0, ien_reg};
      end else if (s_axi_araddr == ssps_pkg::OFS_ESRC || s_axi_araddr == ssps_pkg::OFS_ICLR) begin
        s_axi_rdata <= 32'h0;
      end else begin
        s_axi_rdata <= 32'h0;
        s_axi_rresp <= ssps_pkg::RESP_ERR;
      end
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule

`default_nettype wire

// File: testbench/ssps_monitor.sv
/*
  ssps_monitor: port-level assertions for ssps_top.
  assumes: one clock domain; IDLE_CYCLES well above six cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module ssps_monitor #(
  parameter longint unsigned IDLE_CYCLES = 20  // owner idle span
) (
  // clock and reset
  input wire logic               core_clk,
  input wire logic               rst_n,
  // port traffic
  input wire ssps_pkg::ssps_rx_t serial_rx,
  input wire ssps_pkg::ssps_rx_t gpib_rx,
  input wire ssps_pkg::ssps_rx_t cmd_rx,
  input wire logic               cmd_end,
  // buffer state and status outputs
  input wire logic               resp_pending,
  input wire logic [7:0]         status_byte,
  input wire logic               srq_req
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ****************************************
  // sequences
  // ****************************************
  // serial byte taken while the other port is quiet
  sequence s_serial_take;
    serial_rx.rx_valid && !gpib_rx.rx_valid ##1 cmd_rx.rx_valid;
  endsequence
  // ieee-488 byte arriving alone
  sequence s_gpib_alone;
    gpib_rx.rx_valid && !serial_rx.rx_valid;
  endsequence
  // ****************************************
  // assertions
  // ****************************************
  chk_take_cause: assert property (cmd_rx.rx_valid |-> $past(serial_rx.rx_valid || gpib_rx.rx_valid))
    else $error("byte accepted without traffic");
  chk_owner_holds: assert property (s_serial_take ##[1:5] s_gpib_alone |=> !cmd_rx.rx_valid)
    else $error("non-owner byte accepted");
  chk_srq_mirror: assert property (srq_req == status_byte[6])
    else $error("service request differs from summary bit");
  chk_mss_cause: assert property (status_byte[6] |-> (|status_byte[5:4]) || (|$past(status_byte[5:4])))
    else $error("summary bit without a status bit");
  chk_mav_tracks: assert property (status_byte[4] == $past(resp_pending))
    else $error("message bit does not follow buffer");
  chk_eoi_ends: assert property ($past(gpib_rx.rx_valid && gpib_rx.eoi) && cmd_rx.eoi |-> cmd_end)
    else $error("end marker did not end command");
  chk_newline_ends: assert property (cmd_rx.rx_valid && cmd_rx.rx_data == 8'h0A |-> cmd_end)
    else $error("newline did not end command");
  chk_end_byte: assert property (cmd_end |-> cmd_rx.rx_valid)
    else $error("command end without byte");
endmodule
bind ssps_top ssps_monitor #(.IDLE_CYCLES(IDLE_CYCLES)) u_mon (.core_clk, .rst_n, .serial_rx, .gpib_rx,
  .cmd_rx, .cmd_end, .resp_pending, .status_byte, .srq_req);
`default_nettype wire

// File: testbench/ssps_ctrl_model.sv
/*
  ssps_ctrl_model: remote controller on the serial and ieee-488 ports.
  assumes: the bench calls send, one byte per call.
*/
`timescale 1ns/1ps
`default_nettype none
module ssps_ctrl_model (
  // clock
  input  wire logic              core_clk,
  // traffic toward the block
  output var ssps_pkg::ssps_rx_t serial_rx,
  output var ssps_pkg::ssps_rx_t gpib_rx
);
  // idle lines carry junk, never a stale byte
  initial begin
    serial_rx = '{1'b0, 8'hFF, 1'b1};
    gpib_rx   = '{1'b0, 8'hFF, 1'b1};
  end
  // one-cycle byte after gap+1 idle cycles
  task automatic send(input bit gp, input logic [7:0] b, input bit eoi, input int gap);
    ssps_pkg::ssps_rx_t v;
    v = '{1'b1, b, gp & eoi};  // end marker only on last ieee-488 byte
    repeat (gap) @(posedge core_clk);
    @(posedge core_clk);
    if (gp) gpib_rx <= v;
    else serial_rx <= v;
    @(posedge core_clk);
    // released line shows the inverse of the last byte
    if (gp) gpib_rx <= '{1'b0, ~b, ~v.eoi};
    else serial_rx <= '{1'b0, ~b, ~v.eoi};
  endtask
endmodule
`default_nettype wire

// File: testbench/status_summary_and_port_select_bench.sv
/*
  status_summary_and_port_select_bench: self-checking bench for ssps_top.
  assumes: ssps_ctrl_model drives the ports; ssps_monitor is bound to uut.
*/
`timescale 1ns/1ps
`default_nettype none
module status_summary_and_port_select_bench;
  localparam longint unsigned IDLE = 20;  // shortened idle span
  logic        core_clk, rst_n, cmd_end, resp_pending, srq_req, irq;
  logic [7:0]  event_pulse, status_byte, s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  wire ssps_pkg::ssps_rx_t serial_rx, gpib_rx, cmd_rx;
  logic [1:0]  q_b[$];  // expected write responses
  logic [33:0] q_r[$];  // expected {rresp, rdata}
  logic [10:0] q_c[$];  // expected {cmd_rx, cmd_end}
  int          n_errors = 0, total_checks = 0, seed = 20906;
  logic [7:0]  esr_m, ese_v, sre_v, ev;  // reference copies
  logic        esb, mav, mss;
  ssps_top #(.IDLE_CYCLES(IDLE)) uut (.*);
  ssps_ctrl_model ctrl (.core_clk, .serial_rx, .gpib_rx);
  // 40 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // ****************************************
  // checking
  // ****************************************
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (n_errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // oldest note against each answer
  always @(posedge core_clk) begin
    if (s_axi_bvalid && s_axi_bready) chk(s_axi_bresp, q_b.size() ? q_b.pop_front() : 'x);
    if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, q_r.size() ? q_r.pop_front() : 'x);
    if (cmd_rx.rx_valid || cmd_end) chk({cmd_rx, cmd_end}, q_c.size() ? q_c.pop_front() : 'x);
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    tally_and_finish();
  end
  // ****************************************
  // drivers
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bit aw, w;
    q_b.push_back(r);
    aw = 1;
    w = 1;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // release each channel once taken
    while (aw || w) begin
      @(posedge core_clk);
      if (s_axi_awready) aw = 0;
      if (s_axi_wready) w = 0;
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end
    do @(posedge core_clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    q_r.push_back(e);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask
  // one byte; acc says whether the block should pass it on
  task automatic rx(input bit gp, input logic [7:0] b, input bit eoi, input bit acc);
    if (acc) q_c.push_back({1'b1, b, gp & eoi, b == 8'h0A || (gp & eoi)});
    ctrl.send(gp, b, eoi, $random(seed) & 3);
  endtask
  task automatic settle;
    repeat (3) @(negedge core_clk);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    {rst_n, event_pulse, resp_pending, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    // reset values, refusals
    rd(ssps_pkg::OFS_SRE, 34'h0);
    rd(ssps_pkg::OFS_ESE, 34'h0);
    rd(ssps_pkg::OFS_IEN, 34'h0);
    rd(8'h24, {ssps_pkg::RESP_ERR, 32'h0});
    rd(ssps_pkg::OFS_ESRC, 34'h0);
    wr(ssps_pkg::OFS_STB, 32'hFF, ssps_pkg::RESP_ERR);
    wr(8'h24, 32'h1, ssps_pkg::RESP_ERR);
    // first talker owns the link, other is ignored
    rx(1, 8'h41, 0, 1);
    rx(1, 8'h42, 1, 1);
    rx(0, 8'h0A, 0, 0);
    rd(ssps_pkg::OFS_PORT, 34'h2);
    rd(ssps_pkg::OFS_IST, 34'h3);
    wr(ssps_pkg::OFS_IEN, 32'h1, ssps_pkg::RESP_OK);
    settle;
    chk(irq, 1);
    wr(ssps_pkg::OFS_ICLR, 32'h7, ssps_pkg::RESP_OK);
    settle;
    chk(irq, 0);
    // idle expiry lets the other port take over
    repeat (IDLE + 10) @(posedge core_clk);
    rd(ssps_pkg::OFS_PORT, 34'h6);
    rx(0, 8'h78, 0, 1);
    rx(0, 8'h0A, 0, 1);
    rx(1, 8'h55, 1, 0);
    rd(ssps_pkg::OFS_PORT, 34'h1);
    settle;
    chk(irq, 1);
    wr(ssps_pkg::OFS_IEN, 32'h0, ssps_pkg::RESP_OK);
    settle;
    chk(irq, 0);
    // status byte from random events, masks and buffer state
    esr_m = 8'h00;
    for (int i = 0; i < 8; i++) begin
      ese_v = $random(seed);
      sre_v = $random(seed);
      ev = $random(seed);
      wr(ssps_pkg::OFS_ESE, {24'h0, ese_v}, ssps_pkg::RESP_OK);
      wr(ssps_pkg::OFS_SRE, {24'h0, sre_v}, ssps_pkg::RESP_OK);
      event_pulse <= ev;
      resp_pending <= ev[0];
      @(posedge core_clk);
      event_pulse <= 8'h00;
      esr_m = esr_m | ev;
      esb = |(esr_m & ese_v);
      mav = ev[0];
      mss = (esb & sre_v[5]) | (mav & sre_v[4]);
      rd(ssps_pkg::OFS_ESR, {2'h0, 24'h0, esr_m});
      rd(ssps_pkg::OFS_STB, {2'h0, 24'h0, 1'b0, mss, esb, mav, 4'h0});
      chk(srq_req, mss);
      if (i[0]) begin
        wr(ssps_pkg::OFS_ESRC, 32'hFF, ssps_pkg::RESP_OK);
        esr_m = 8'h00;
      end
    end
    resp_pending <= 1'b0;
    settle;
    chk(status_byte[4], 0);
    // summary rising edge raises its own interrupt bit
    wr(ssps_pkg::OFS_ICLR, 32'h7, ssps_pkg::RESP_OK);
    rd(ssps_pkg::OFS_IST, 34'h0);
    resp_pending <= 1'b1;
    wr(ssps_pkg::OFS_SRE, 32'h10, ssps_pkg::RESP_OK);
    rd(ssps_pkg::OFS_IST, 34'h4);
    chk(srq_req, 1);
    chk(q_c.size(), 0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
